// File: design/hpms_top.sv
// host port mode select: pin routing, sleep, queue strap, serial shift
// Behaviour
// - sleep request high powers analog down
// - serial port keeps working while asleep
// - write queue only with strap and parallel
// - strap sampled at power-up, clear, reset
// - select high, protocol low: four-wire port
// - select high, protocol high: two-wire port
// - parallel mode: shared pins are bits 9-11
// - serial mode: bit-10 pin is clock
// - four-wire shifts in on falling clock edge
// - two-wire supports 100 and 400 kHz
// - two-wire data pin is open drain
// - four-wire readback shifts out on rising edges
// - parallel bit 11 msb, bit 0 lsb
`timescale 1ns/1ps
`default_nettype none
`include "hpms_params.svh"
module hpms_top #(
  parameter int WORD_W = `HPMS_WORD_W,
  parameter int SHIFT_W = `HPMS_SHIFT_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sleep_request,
  input wire logic write_queue_enable,
  input wire logic host_port_select,
  input wire logic clear_event,
  input wire logic [WORD_W-1:0] par_data_in,
  input wire logic par_strobe,
  input wire logic sdo_load,
  input wire logic [SHIFT_W-1:0] sdo_load_word,
  output logic analog_sleep,
  output logic queue_enabled,
  output logic [1:0] port_mode,
  output logic [WORD_W-1:0] par_word,
  output logic par_word_valid,
  output logic [SHIFT_W-1:0] serial_word,
  output logic serial_word_valid,
  output logic serial_output,
  output logic sda_out,
  output logic sda_oe
);
  // synchronised pins
  logic sleep_s, strap_s, sel_s, clr_s, strobe_s;
  logic [WORD_W-1:0] bus_s;
  logic clr_prev_q, strobe_prev_q, clk_prev_q, first_q;
  logic sel_prev_q; // serial select one cycle ago, masks entry glitch
  logic [1:0] settle_q; // counts synchroniser refill after reset
  logic [SHIFT_W-1:0] shift_q, out_q;
  logic [$clog2(SHIFT_W+1)-1:0] cnt_q;
  hpms_pkg::hpms_mode_type mode;
  logic clk_fall, clk_rise;

  hpms_sync u_sleep (.clock(clock), .rst(rst), .async_in(sleep_request), .sync_out(sleep_s));
  hpms_sync u_strap (.clock(clock), .rst(rst), .async_in(write_queue_enable), .sync_out(strap_s));
  hpms_sync u_sel (.clock(clock), .rst(rst), .async_in(host_port_select), .sync_out(sel_s));
  hpms_sync u_clr (.clock(clock), .rst(rst), .async_in(clear_event), .sync_out(clr_s));
  hpms_sync u_stb (.clock(clock), .rst(rst), .async_in(par_strobe), .sync_out(strobe_s));
  // one synchroniser per bus bit
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_bus
      hpms_sync u_bit (.clock(clock), .rst(rst), .async_in(par_data_in[gi]), .sync_out(bus_s[gi]));
    end
  endgenerate

  // mode decode from select and protocol pin
  always_comb begin
    if (!sel_s) begin
      mode = hpms_pkg::hpms_par_type_e;
    end else if (bus_s[`HPMS_PROTO_BIT]) begin
      mode = hpms_pkg::hpms_i2c_type_e;
    end else begin
      mode = hpms_pkg::hpms_spi_type_e;
    end
  end

  // shared clock pin edges, serial modes only
  // no edge in the first serial cycle: history still holds the parallel bit
  assign clk_fall = sel_s && sel_prev_q && clk_prev_q && !bus_s[`HPMS_CLK_BIT];
  assign clk_rise = sel_s && sel_prev_q && !clk_prev_q && bus_s[`HPMS_CLK_BIT];

  // edge history registers
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
      settle_q <= 2'b00;
      first_q <= 1'b0;
    end else begin
      clk_prev_q <= bus_s[`HPMS_CLK_BIT];
      clr_prev_q <= clr_s;
      strobe_prev_q <= strobe_s;
      sel_prev_q <= sel_s;
      settle_q <= {settle_q[0], 1'b1};
      // one sample pulse once the strap synchroniser holds the pin again
      first_q <= (settle_q == 2'b01);
    end
  end

  // analog sleep level, serial untouched
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_sleep <= 1'b0;
    end else begin
      analog_sleep <= sleep_s;
    end
  end

  // strap caught after reset, once synchronisers refill, and on clear edge
  logic strap_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_q <= `HPMS_QUEUE_RST;
    end else if (first_q || (clr_s && !clr_prev_q)) begin
      strap_q <= strap_s;
    end
  end

  // queue only in parallel mode
  always_ff @(posedge clock) begin
    if (rst) begin
      queue_enabled <= 1'b0;
      port_mode <= 2'b00;
    end else begin
      queue_enabled <= strap_q && (mode == hpms_pkg::hpms_par_type_e);
      port_mode <= mode;
    end
  end

  // parallel word capture on strobe rise, bit 11 msb
  always_ff @(posedge clock) begin
    if (rst) begin
      par_word <= '0;
      par_word_valid <= 1'b0;
    end else begin
      par_word_valid <= 1'b0;
      if (mode == hpms_pkg::hpms_par_type_e && strobe_s && !strobe_prev_q) begin
        par_word <= bus_s;
        par_word_valid <= 1'b1;
      end
    end
  end

  // serial shift in on falling edges, ignores sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_q <= '0;
      cnt_q <= '0;
      serial_word <= '0;
      serial_word_valid <= 1'b0;
    end else begin
      serial_word_valid <= 1'b0;
      if (clk_fall) begin
        shift_q <= {shift_q[SHIFT_W-2:0], bus_s[`HPMS_DATA_BIT]};
        if (cnt_q == ($clog2(SHIFT_W+1))'(SHIFT_W-1)) begin
          cnt_q <= '0;
          serial_word <= {shift_q[SHIFT_W-2:0], bus_s[`HPMS_DATA_BIT]};
          serial_word_valid <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (!sel_s) begin
        cnt_q <= '0;
      end
    end
  end

  // four-wire readback shifts out on rising edges
  always_ff @(posedge clock) begin
    if (rst) begin
      out_q <= '0;
      serial_output <= 1'b0;
    end else if (sdo_load) begin
      // msb goes out at once so it stands before the first falling edge
      serial_output <= sdo_load_word[SHIFT_W-1];
      out_q <= {sdo_load_word[SHIFT_W-2:0], 1'b0};
    end else if (clk_rise && mode == hpms_pkg::hpms_spi_type_e) begin
      serial_output <= out_q[SHIFT_W-1];
      out_q <= {out_q[SHIFT_W-2:0], 1'b0};
    end
  end

  // open drain data pin: only pull low, two-wire mode
  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= (mode == hpms_pkg::hpms_i2c_type_e) && clk_rise && !out_q[SHIFT_W-1];
    end
  end

  // checks
  property p_sleep;
    @(posedge clock) disable iff (rst) sleep_s |=> analog_sleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not applied");
  property p_queue;
    @(posedge clock) disable iff (rst) queue_enabled |-> !port_mode[0];
  endproperty
  a_queue: assert property (p_queue) else $error("queue on in serial mode");
  property p_strap;
    @(posedge clock) disable iff (rst) !first_q && !(clr_s && !clr_prev_q) |=> $stable(strap_q);
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed outside event");
  property p_spi;
    @(posedge clock) disable iff (rst) sel_s && !bus_s[`HPMS_PROTO_BIT] |=> port_mode == 2'b01;
  endproperty
  a_spi: assert property (p_spi) else $error("four-wire mode not chosen");
  property p_i2c;
    @(posedge clock) disable iff (rst) sel_s && bus_s[`HPMS_PROTO_BIT] |=> port_mode == 2'b11;
  endproperty
  a_i2c: assert property (p_i2c) else $error("two-wire mode not chosen");
  property p_par;
    @(posedge clock) disable iff (rst) par_word_valid |-> !port_mode[0];
  endproperty
  a_par: assert property (p_par) else $error("parallel word in serial mode");
  property p_shift;
    @(posedge clock) disable iff (rst) clk_fall |=> shift_q[0] == $past(bus_s[`HPMS_DATA_BIT]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted in");
  property p_od;
    @(posedge clock) disable iff (rst) sda_oe |-> !sda_out && port_mode == 2'b11;
  endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_load;
    @(posedge clock) disable iff (rst) sdo_load |=> serial_output == $past(sdo_load_word[SHIFT_W-1]);
  endproperty
  a_load: assert property (p_load) else $error("readback msb not presented");
endmodule
`default_nettype wire

// File: shared/hpms_params.svh
// constants for the host port mode select block
`ifndef HPMS_PARAMS_SVH
`define HPMS_PARAMS_SVH
`define HPMS_WORD_W 12
`define HPMS_PROTO_BIT 9
`define HPMS_CLK_BIT 10
`define HPMS_DATA_BIT 11
`define HPMS_SHIFT_W 24
`define HPMS_SPI_MAX_KHZ 50000
`define HPMS_I2C_STD_KHZ 100
`define HPMS_I2C_FAST_KHZ 400
`define HPMS_QUEUE_RST 1'b0
`endif

// File: shared/hpms_pkg.sv
// types for the host port mode select block
package hpms_pkg;
  // selected host port, gray coded
  typedef enum logic [1:0] {
    hpms_par_type_e = 2'b00,
    hpms_spi_type_e = 2'b01,
    hpms_i2c_type_e = 2'b11
  } hpms_mode_type;
endpackage

// File: design/hpms_sync.sv
// two flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module hpms_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q; // first stage, read only by second
  // two stage capture
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: bench/hpms_host.sv
// host model driving the shared clock and data pins
`timescale 1ns/1ps
`default_nettype none
module hpms_host (
  input wire logic go,
  input wire logic [23:0] word,
  output logic sclk,
  output logic sdata,
  output logic busy
);
  // clock idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
    busy = 1'b0;
  end
  // one 24 bit frame msb first, 320 ns period
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      sdata = word[i];
      #160 sclk = 1'b0;
      #160 sclk = 1'b1;
    end
    // released data line shows the inverse of the last bit
    sdata = ~sdata;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
// self checking bench for the host port mode select block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sleep_request = 1'b0;
  logic write_queue_enable = 1'b1;
  logic host_port_select = 1'b0;
  logic clear_event = 1'b0;
  logic par_strobe = 1'b0;
  logic sdo_load = 1'b0;
  logic go = 1'b0;
  logic [11:0] pbus = 12'h000;
  logic [23:0] sdo_load_word = 24'h000000;
  logic [23:0] host_word = 24'h000000;
  logic [23:0] rb = 24'h000000;
  logic got, stray, pulled;
  wire logic host_clk, host_dat, host_busy;
  wire logic [11:0] par_data_in;
  logic analog_sleep, queue_enabled, par_word_valid, serial_word_valid, serial_output, sda_out, sda_oe;
  logic [1:0] port_mode;
  logic [11:0] par_word;
  logic [23:0] serial_word;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // host owns the top two pins only in serial modes
  assign par_data_in = host_port_select ? {host_dat, host_clk, pbus[9:0]} : pbus;
  always #20 clock = ~clock;
  hpms_host u_host (.go(go), .word(host_word), .sclk(host_clk), .sdata(host_dat), .busy(host_busy));
  hpms_top u_dut (.clock(clock), .rst(rst), .sleep_request(sleep_request),
    .write_queue_enable(write_queue_enable), .host_port_select(host_port_select),
    .clear_event(clear_event), .par_data_in(par_data_in), .par_strobe(par_strobe),
    .sdo_load(sdo_load), .sdo_load_word(sdo_load_word), .analog_sleep(analog_sleep),
    .queue_enabled(queue_enabled), .port_mode(port_mode), .par_word(par_word),
    .par_word_valid(par_word_valid), .serial_word(serial_word), .serial_word_valid(serial_word_valid),
    .serial_output(serial_output), .sda_out(sda_out), .sda_oe(sda_oe));
  // readback bits as the host sees them at falling edges
  always @(negedge host_clk) rb <= {rb[22:0], serial_output};
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic conclude;
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude;
    end
  end
  // one host frame, watching strays meanwhile
  task automatic frame(input logic [23:0] w);
    while (host_busy === 1'b1) tick(1);
    host_word = w;
    go = 1'b1;
    got = 1'b0;
    stray = 1'b0;
    pulled = 1'b0;
    for (int i = 0; i < 260 && !got; i++) begin
      tick(1);
      if (serial_word_valid === 1'b1) got = 1'b1;
      if (par_word_valid === 1'b1) stray = 1'b1;
      if (sda_oe === 1'b1) pulled = 1'b1;
    end
    go = 1'b0;
  endtask
  task automatic clr(input logic strap);
    write_queue_enable = strap;
    tick(4);
    clear_event = 1'b1;
    tick(6);
    clear_event = 1'b0;
  endtask
  task automatic t_strap;
    tick(2);
    chk(queue_enabled, 1);
    clr(1'b0);
    chk(queue_enabled, 0);
    write_queue_enable = 1'b1;
    tick(8);
    chk(queue_enabled, 0);
    clr(1'b1);
    chk(queue_enabled, 1);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(5);
    chk(queue_enabled, 1);
  endtask
  task automatic t_par;
    pbus = 12'ha5c;
    par_strobe = 1'b1;
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      tick(1);
      if (par_word_valid === 1'b1) got = 1'b1;
    end
    par_strobe = 1'b0;
    chk(par_word, 12'ha5c);
    chk(port_mode, 2'b00);
  endtask
  task automatic t_spi;
    host_port_select = 1'b1;
    write_queue_enable = 1'b0;
    pbus = 12'h000;
    sleep_request = 1'b1;
    sdo_load_word = 24'h96e1b4;
    sdo_load = 1'b1;
    tick(1);
    sdo_load = 1'b0;
    tick(6);
    chk(port_mode, 2'b01);
    chk(analog_sleep, 1);
    chk(queue_enabled, 0);
    par_strobe = 1'b1;
    frame(24'hc3a51e);
    par_strobe = 1'b0;
    chk(serial_word, 24'hc3a51e);
    chk(stray, 0);
    chk(rb, 24'h96e1b4);
    sleep_request = 1'b0;
    tick(6);
    chk(analog_sleep, 0);
  endtask
  task automatic t_i2c;
    pbus[9] = 1'b1;
    sdo_load_word = 24'h000000;
    sdo_load = 1'b1;
    tick(1);
    sdo_load = 1'b0;
    tick(6);
    chk(port_mode, 2'b11);
    frame(24'h5a0f33);
    chk(serial_word, 24'h5a0f33);
    chk(pulled, 1);
    chk(sda_out, 0);
  endtask
  initial begin
    tick(2);
    rst = 1'b0;
    tick(3);
    t_strap;
    t_par;
    t_spi;
    t_i2c;
    conclude;
  end
endmodule
`default_nettype wire
